// File: core/asrp_pkg.sv
// Constants, register map and state codes for the serial result port.
// Assumes one 125 MHz reference clock drives all of the port's logic.
package asrp_pkg;

	localparam int CHAN_W = 4;
	localparam int RES_W = 12;
	localparam int CNT_W = 12;
	localparam int SYNC_W = 8;
	localparam int APB_AW = 8;

	// Timing, figures in microseconds and MHz
	localparam int REF_CLK_MHZ = 125;
	localparam int SETTLE_US = 10;
	localparam int CONV_US = 15;
	localparam logic [CNT_W-1:0] SETTLE_CYC = CNT_W'(SETTLE_US * REF_CLK_MHZ);
	localparam logic [CNT_W-1:0] CONV_CYC = CNT_W'(CONV_US * REF_CLK_MHZ);

	// Serial framing
	localparam logic [3:0] LAST_BIT = 4'hb;
	localparam int MSB_POS = RES_W - 1;

	// Register byte offsets
	localparam logic [APB_AW-1:0] OFS_SAMPLE = 8'h00;
	localparam logic [APB_AW-1:0] OFS_STATUS = 8'h04;
	localparam logic [APB_AW-1:0] OFS_RESULT = 8'h08;

	// Values after reset
	localparam logic [RES_W-1:0] SAMPLE_RST = 12'h000;
	localparam logic [CHAN_W-1:0] CHAN_RST = 4'h0;
	localparam logic [SYNC_W-1:0] SYNC_RST = 8'hf0;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SETTLE = 2'b01,
		ST_CONV = 2'b11,
		ST_HOLD = 2'b10
	} asrp_state_t;

endpackage

// File: core/asrp_sync.sv
// Two-stage synchroniser for a group of asynchronous level inputs.
// Assumes inputs change slowly against the clock; no bus coherency.
`timescale 1ns/1ps
module asrp_sync #(
	parameter int W = 8,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Levels
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] meta_q;

	// The first stage feeds only the second
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			meta_q <= RST_VAL;
			q <= RST_VAL;
		end
		else
		begin
			meta_q <= d;
			q <= meta_q;
		end
	end

endmodule

// File: core/asrp_top.sv
// Conversion control and serial result port with an APB register slave.
// Assumes host pins are asynchronous; SAMPLE stands in for the analog code.
`timescale 1ns/1ps

// Notes on behaviour
// RULE_01: Result leaves serially, most significant bit first, least last.
// RULE_02: Top bit is on the serial output as busy falls, no clock needed.
// RULE_03: Each falling serial clock edge moves to the next lower bit.
// RULE_04: Eleventh falling serial clock edge after conversion shows last bit.
// RULE_05: Host keeps the serial clock high while busy is high.
// RULE_06: Host waits the first edge delay after busy falls before clocking.
// RULE_07: Strobe fall with latch enable high picks channel and raises settle.
// RULE_08: Strobe fall with address latch enable low changes nothing.
// RULE_09: Settle already low: conversion starts on strobe rise.
// RULE_10: Strobe high during settle: conversion starts when settle falls.
// RULE_11: Busy is high during conversion and drops when it completes.
// RULE_12: Read enable low and not busy drives output and accepts clock edges.
// RULE_13: Read enable high keeps the serial output released.
// RULE_14: While busy, output, serial clock and read enable have no effect.
// RULE_15: Address latch enable low keeps settle low and the old channel.
// RULE_16: The new result is on the output at the fall of busy.
// RULE_17: Host holds read enable steady, preferably high, during conversion.
// RULE_18: Results are 12-bit two's complement codes.
// RULE_19: Channel address is taken on the strobe's falling edge.
// RULE_20: Strobes are ignored once settle or busy is high until done.
// RULE_21: Host counts twelve bits per result before releasing read enable.
module asrp_top (
	// Clock and reset
	input wire logic REF_CLK,
	input wire logic ARST_N,
	// APB slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [asrp_pkg::APB_AW-1:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// Conversion control pins
	input wire logic CONVERT_STROBE_N,
	input wire logic ADDRESS_LATCH_ENABLE,
	input wire logic [asrp_pkg::CHAN_W-1:0] CHAN_ADDR,
	output logic SETTLE_FLAG,
	output logic CONVERSION_BUSY,
	output logic [asrp_pkg::CHAN_W-1:0] CHANNEL_SEL,
	// Serial result pins
	input wire logic READ_ENABLE_N,
	input wire logic SERIAL_CLOCK_IN,
	output logic SERIAL_OUT,
	output logic SERIAL_OUT_OE_N
);

	import asrp_pkg::*;

	logic [SYNC_W-1:0] pins_s;
	logic sdc_s;
	logic rd_n_s;
	logic address_latch_enable_s;
	logic wr_n_s;
	logic [CHAN_W-1:0] addr_s;
	logic wr_n_q;
	logic sdc_q;
	logic wr_fall;
	logic wr_rise;
	logic sdc_fall;
	asrp_state_t state_q;
	asrp_state_t state_d;
	logic [CNT_W-1:0] cnt_q;
	logic settle_done;
	logic conv_done;
	logic busy_d;
	logic [RES_W-1:0] sample_q;
	logic [RES_W-1:0] result_q;
	logic [RES_W-1:0] sh_q;
	logic [3:0] bit_cnt_q;
	logic apb_acc;
	logic apb_hit;
	logic [31:0] rd_mux;

	// Every pin from the host is asynchronous
	asrp_sync #(
		.W(SYNC_W),
		.RST_VAL(SYNC_RST)
	) u_sync (
		.clk(REF_CLK),
		.arst_n(ARST_N),
		.d({SERIAL_CLOCK_IN, READ_ENABLE_N, ADDRESS_LATCH_ENABLE,
			CONVERT_STROBE_N, CHAN_ADDR}),
		.q(pins_s)
	);

	assign sdc_s = pins_s[7];
	assign rd_n_s = pins_s[6];
	assign address_latch_enable_s = pins_s[5];
	assign wr_n_s = pins_s[4];
	assign addr_s = pins_s[3:0];

	// Edge detection on synchronised levels only
	always_ff @(posedge REF_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			wr_n_q <= 1'b1;
			sdc_q <= 1'b1;
		end
		else
		begin
			wr_n_q <= wr_n_s;
			sdc_q <= sdc_s;
		end
	end

	assign wr_fall = wr_n_q & ~wr_n_s;
	assign wr_rise = ~wr_n_q & wr_n_s;
	assign sdc_fall = sdc_q & ~sdc_s;

	assign settle_done = (state_q == ST_SETTLE) && (cnt_q == SETTLE_CYC - 1'b1);
	assign conv_done = (state_q == ST_CONV) && (cnt_q == CONV_CYC - 1'b1);

	// Strobes outside idle and hold fall through untouched [RULE_20]
	always_comb
	begin
		state_d = state_q;
		unique case (state_q)
			ST_IDLE:
			begin
				if (wr_fall && address_latch_enable_s)
					state_d = ST_SETTLE; // [RULE_07]
				else if (wr_rise)
					state_d = ST_CONV; // [RULE_15]
			end
			ST_SETTLE:
			begin
				if (settle_done)
					state_d = wr_n_s ? ST_CONV : ST_HOLD; // [RULE_10]
			end
			ST_HOLD:
			begin
				if (wr_rise)
					state_d = ST_CONV; // [RULE_09]
			end
			ST_CONV:
			begin
				if (conv_done)
					state_d = ST_IDLE;
			end
		endcase
	end

	assign busy_d = (state_d == ST_CONV);

	always_ff @(posedge REF_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			state_q <= ST_IDLE;
		else
			state_q <= state_d;
	end

	// One timer serves settling and conversion
	always_ff @(posedge REF_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			cnt_q <= '0;
		else if (state_d != state_q)
			cnt_q <= '0;
		else
			cnt_q <= cnt_q + 1'b1;
	end

	// Flags follow the next state so they change on the deciding edge
	always_ff @(posedge REF_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			SETTLE_FLAG <= 1'b0;
			CONVERSION_BUSY <= 1'b0;
		end
		else
		begin
			SETTLE_FLAG <= (state_d == ST_SETTLE); // [RULE_15]
			CONVERSION_BUSY <= busy_d; // [RULE_11]
		end
	end

	// Address is caught with the strobe fall, else the old channel stays
	always_ff @(posedge REF_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			CHANNEL_SEL <= CHAN_RST;
		else if (state_q == ST_IDLE && wr_fall && address_latch_enable_s)
			CHANNEL_SEL <= addr_s; // [RULE_07] [RULE_19] [RULE_08]
	end

	// Driver released while busy or while read enable is high
	always_ff @(posedge REF_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			SERIAL_OUT_OE_N <= 1'b1;
		else
			SERIAL_OUT_OE_N <= rd_n_s | busy_d; // [RULE_12] [RULE_13] [RULE_14]
	end

	// Result capture and serial shifting
	always_ff @(posedge REF_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			result_q <= SAMPLE_RST;
			sh_q <= SAMPLE_RST;
			bit_cnt_q <= 4'h0;
			SERIAL_OUT <= 1'b0;
		end
		else if (conv_done)
		begin
			// Code is kept as two's complement, no offset applied [RULE_18]
			result_q <= sample_q;
			sh_q <= sample_q;
			bit_cnt_q <= 4'h0;
			SERIAL_OUT <= sample_q[MSB_POS]; // [RULE_02] [RULE_16]
		end
		else if (!CONVERSION_BUSY && !rd_n_s && sdc_fall &&
			bit_cnt_q != LAST_BIT)
		begin
			// Extra clocks after the last bit leave it standing
			sh_q <= {sh_q[RES_W-2:0], 1'b0}; // [RULE_01] [RULE_03]
			SERIAL_OUT <= sh_q[RES_W-2];
			bit_cnt_q <= bit_cnt_q + 1'b1; // [RULE_04] [RULE_12]
		end
	end

	// APB: one wait state, write and read data on the pready edge
	assign apb_acc = PSEL & PENABLE;
	assign apb_hit = (PADDR == OFS_SAMPLE) || (PADDR == OFS_STATUS) ||
		(PADDR == OFS_RESULT);

	always_comb
	begin
		rd_mux = 32'h0000_0000;
		unique case (PADDR)
			OFS_SAMPLE: rd_mux = {20'h00000, sample_q};
			OFS_STATUS: rd_mux = {20'h00000, bit_cnt_q, CHANNEL_SEL,
				2'b00, SETTLE_FLAG, CONVERSION_BUSY};
			OFS_RESULT: rd_mux = {20'h00000, result_q};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge REF_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			PREADY <= 1'b0;
			PRDATA <= 32'h0000_0000;
			PSLVERR <= 1'b0;
		end
		else if (apb_acc && !PREADY)
		begin
			PREADY <= 1'b1;
			PRDATA <= PWRITE ? 32'h0000_0000 : rd_mux;
			PSLVERR <= ~apb_hit;
		end
		else
		begin
			PREADY <= 1'b0;
			PRDATA <= 32'h0000_0000;
			PSLVERR <= 1'b0;
		end
	end

	// Sample code may change at any time; it is taken at conversion end
	always_ff @(posedge REF_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			sample_q <= SAMPLE_RST;
		else if (apb_acc && PREADY && PWRITE && PADDR == OFS_SAMPLE)
			sample_q <= PWDATA[RES_W-1:0];
	end

	property p_bit_order;
		@(posedge REF_CLK) disable iff (!ARST_N)
		!CONVERSION_BUSY |-> SERIAL_OUT == result_q[LAST_BIT - bit_cnt_q];
	endproperty
	a_bit_order: assert property (p_bit_order) // [RULE_01]
		else $error("serial bit does not match result position");

	property p_msb_at_fall;
		@(posedge REF_CLK) disable iff (!ARST_N)
		$fell(CONVERSION_BUSY) |-> SERIAL_OUT == result_q[MSB_POS] &&
			result_q == $past(sample_q) && bit_cnt_q == 4'h0;
	endproperty
	a_msb_at_fall: assert property (p_msb_at_fall) // [RULE_02]
		else $error("top bit not presented when busy fell");

	property p_shift_step;
		@(posedge REF_CLK) disable iff (!ARST_N)
		!CONVERSION_BUSY && !rd_n_s && sdc_fall && bit_cnt_q < LAST_BIT
		|=> bit_cnt_q == $past(bit_cnt_q) + 1'b1;
	endproperty
	a_shift_step: assert property (p_shift_step) // [RULE_03]
		else $error("falling serial clock did not advance the bit");

	property p_lsb_last;
		@(posedge REF_CLK) disable iff (!ARST_N)
		!CONVERSION_BUSY && !rd_n_s && sdc_fall && bit_cnt_q == 4'ha
		|=> SERIAL_OUT == result_q[0] && bit_cnt_q == LAST_BIT;
	endproperty
	a_lsb_last: assert property (p_lsb_last) // [RULE_04]
		else $error("last bit not shown after eleventh edge");

	property p_select;
		@(posedge REF_CLK) disable iff (!ARST_N)
		state_q == ST_IDLE && wr_fall && address_latch_enable_s
		|=> SETTLE_FLAG && CHANNEL_SEL == $past(addr_s);
	endproperty
	a_select: assert property (p_select) // [RULE_07]
		else $error("channel not taken or settle not raised");

	property p_no_select;
		@(posedge REF_CLK) disable iff (!ARST_N)
		!address_latch_enable_s && state_q == ST_IDLE |=> !SETTLE_FLAG && $stable(CHANNEL_SEL);
	endproperty
	a_no_select: assert property (p_no_select) // [RULE_15]
		else $error("channel or settle changed with latch enable low");

	property p_start_rise;
		@(posedge REF_CLK) disable iff (!ARST_N)
		state_q == ST_HOLD && wr_rise |=> CONVERSION_BUSY && !SETTLE_FLAG;
	endproperty
	a_start_rise: assert property (p_start_rise) // [RULE_09]
		else $error("strobe rise did not start conversion");

	property p_start_settle;
		@(posedge REF_CLK) disable iff (!ARST_N)
		$fell(SETTLE_FLAG) && $past(wr_n_s) |-> CONVERSION_BUSY;
	endproperty
	a_start_settle: assert property (p_start_settle) // [RULE_10]
		else $error("conversion not started as settle fell");

	property p_busy_length;
		@(posedge REF_CLK) disable iff (!ARST_N)
		$fell(CONVERSION_BUSY) |-> $past(cnt_q) == CONV_CYC - 1'b1;
	endproperty
	a_busy_length: assert property (p_busy_length) // [RULE_11]
		else $error("busy length differs from conversion time");

	property p_drive;
		@(posedge REF_CLK) disable iff (!ARST_N)
		##1 SERIAL_OUT_OE_N == ($past(rd_n_s) | CONVERSION_BUSY);
	endproperty
	a_drive: assert property (p_drive) // [RULE_13]
		else $error("output enable disagrees with read enable and busy");

	property p_busy_frozen;
		@(posedge REF_CLK) disable iff (!ARST_N)
		CONVERSION_BUSY ##1 CONVERSION_BUSY |-> $stable(sh_q) &&
			SERIAL_OUT_OE_N;
	endproperty
	a_busy_frozen: assert property (p_busy_frozen) // [RULE_14]
		else $error("shift or drive active while busy");

	property p_ignore;
		@(posedge REF_CLK) disable iff (!ARST_N)
		(SETTLE_FLAG || CONVERSION_BUSY) && wr_fall |=> $stable(CHANNEL_SEL);
	endproperty
	a_ignore: assert property (p_ignore) // [RULE_20]
		else $error("strobe acted during a conversion cycle");

endmodule

// File: bench/asrp_host.sv
// Host model for the serial result port: strobe, latch enable, address,
// read enable and serial clock. Assumes the 125 MHz reference clock.
`timescale 1ns/1ps
module asrp_host (
	// Clock
	input wire logic clk,
	// Pins towards the port
	output logic strobe_n,
	output logic address_latch_enable,
	output logic [asrp_pkg::CHAN_W-1:0] addr,
	output logic read_n,
	output logic sclk,
	input wire logic serial_out
);
	import asrp_pkg::*;
	initial
	begin
		strobe_n = 1'b1;
		address_latch_enable = 1'b0;
		addr = '0;
		read_n = 1'b1;
		sclk = 1'b1; // Stands high outside frames and while busy
	end
	// Read enable is only changed between conversions
	task automatic set_pins(input logic en, input logic [CHAN_W-1:0] a,
		input logic rn);
		begin
			@(posedge clk);
			address_latch_enable <= en;
			addr <= a;
			read_n <= rn;
		end
	endtask
	task automatic strobe(input logic lvl, input int hold);
		begin
			@(posedge clk);
			strobe_n <= lvl;
			repeat (hold) @(posedge clk);
		end
	endtask
	// One 160 ns serial clock period, falling half first
	task automatic clock_falls(input int n);
		begin
			repeat (n)
			begin
				@(posedge clk);
				sclk <= 1'b0;
				repeat (10) @(posedge clk);
				sclk <= 1'b1;
				repeat (10) @(posedge clk);
			end
		end
	endtask
	// Twelve bits per result, MSB first, one sample per bit
	task automatic read_word(output logic [RES_W-1:0] w);
		begin
			repeat (5) @(posedge clk); // First edge delay after busy
			w[MSB_POS] = serial_out;
			for (int k = 1; k < RES_W; k++)
			begin
				clock_falls(1);
				w[MSB_POS - k] = serial_out;
			end
		end
	endtask
endmodule

// File: bench/tb.sv
// Self-checking bench: APB master plus host model, conversions over a table
// of codes and modes. Assumes the design package constants and fixed timing.
`timescale 1ns/1ps
module tb;
	import asrp_pkg::*;
	logic clk, arst_n, psel, penable, pwrite, pready, pslverr, err;
	logic [APB_AW-1:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic strobe_n, address_latch_enable, read_n, sclk, settle, busy, serial_out, oe_n;
	logic [CHAN_W-1:0] addr, chan_sel, chan;
	logic [RES_W-1:0] code, word;
	int bad_count, comparisons, seed;
	// A released line must not show the held bit, so it reads inverted
	wire sdo_wire = oe_n ? ~serial_out : serial_out;
	asrp_top asrp_top_inst (.REF_CLK(clk), .ARST_N(arst_n), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.CONVERT_STROBE_N(strobe_n), .ADDRESS_LATCH_ENABLE(address_latch_enable),
		.CHAN_ADDR(addr), .SETTLE_FLAG(settle), .CONVERSION_BUSY(busy),
		.CHANNEL_SEL(chan_sel), .READ_ENABLE_N(read_n),
		.SERIAL_CLOCK_IN(sclk), .SERIAL_OUT(serial_out), .SERIAL_OUT_OE_N(oe_n));
	asrp_host asrp_host_inst (.clk(clk), .strobe_n(strobe_n), .address_latch_enable(address_latch_enable),
		.addr(addr), .read_n(read_n), .sclk(sclk), .serial_out(sdo_wire));
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic print_verdict;
		begin
			$display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
			if (bad_count == 0 && comparisons > 0)
				$display("TB: PASS");
			else
				$display("TB: FAIL");
			$finish;
		end
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		begin
			comparisons++;
			if (seen !== exp)
			begin
				bad_count++;
				$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
			end
		end
	endtask
	task automatic apb(input logic wr, input logic [APB_AW-1:0] a,
		input logic [31:0] wd);
		begin
			@(posedge clk);
			psel <= 1'b1;
			pwrite <= wr;
			paddr <= a;
			pwdata <= wd;
			@(posedge clk);
			penable <= 1'b1;
			for (int n = 0; n < 50 && pready !== 1'b1; n++)
				@(posedge clk);
			rd = prdata;
			err = pslverr;
			check(32'(pready), 32'h1);
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	// Waits a bounded time for a level, then compares it
	// Selects busy when sel_busy is set, else the settle flag
	task automatic wait_lvl(input logic sel_busy, input logic v,
		input int lim);
		begin
			for (int n = 0; n < lim && (sel_busy ? busy : settle) !== v; n++)
				@(posedge clk);
			check(32'(sel_busy ? busy : settle), 32'(v));
		end
	endtask
	task automatic convert(input int i);
		logic [RES_W-1:0] codes [4] = '{12'h7ff, 12'h800, 12'h000, 12'hfff};
		logic en, late, rlow;
		logic [CHAN_W-1:0] a;
		begin
			en = (i != 2);
			late = (i == 3);
			rlow = (i != 4);
			a = CHAN_W'($random(seed));
			code = (i < 4) ? codes[i] : RES_W'($random(seed));
			apb(1'b1, OFS_SAMPLE, 32'(code));
			apb(1'b0, OFS_SAMPLE, 32'h0);
			check(rd, 32'(code));
			asrp_host_inst.set_pins(en, a, ~rlow);
			asrp_host_inst.strobe(1'b0, 5);
			if (en)
			begin
				wait_lvl(1'b0, 1'b1, 20);
				chan = a;
			end
			else
			begin
				repeat (10) @(posedge clk);
				check(32'({settle, busy}), 32'h0);
			end
			check(32'(chan_sel), 32'(chan));
			if (late)
			begin
				wait_lvl(1'b0, 1'b0, 1300);
				repeat (20) @(posedge clk);
				check(32'(busy), 32'h0);
			end
			asrp_host_inst.strobe(1'b1, 1);
			wait_lvl(1'b1, 1'b1, 1300);
			check(32'(settle), 32'h0);
			// A second strobe with a new address lands in mid-conversion
			asrp_host_inst.set_pins(1'b1, ~a, ~rlow);
			asrp_host_inst.strobe(1'b0, 5);
			asrp_host_inst.strobe(1'b1, 5);
			check(32'({settle, chan_sel}), 32'({1'b0, chan}));
			check(32'(oe_n), 32'h1);
			wait_lvl(1'b1, 1'b0, 1900);
			check(32'(serial_out), 32'(code[MSB_POS]));
			if (rlow)
			begin
				repeat (4) @(posedge clk);
				check(32'(oe_n), 32'h0);
				asrp_host_inst.read_word(word);
				check(32'(word), 32'(code));
				asrp_host_inst.clock_falls(1);
				check(32'(sdo_wire), 32'(code[0]));
				apb(1'b0, OFS_STATUS, 32'h0);
				check(rd, {20'h0, LAST_BIT, chan, 4'h0});
			end
			else
			begin
				check(32'(oe_n), 32'h1);
				asrp_host_inst.clock_falls(3);
				asrp_host_inst.set_pins(en, a, 1'b0);
				repeat (5) @(posedge clk);
				check(32'(sdo_wire), 32'(code[MSB_POS]));
			end
			apb(1'b0, OFS_RESULT, 32'h0);
			check(rd, 32'(code));
		end
	endtask
	initial
	begin
		seed = 32'hb55e;
		bad_count = 0;
		comparisons = 0;
		arst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		repeat (5) @(posedge clk);
		arst_n <= 1'b1;
		apb(1'b0, OFS_STATUS, 32'h0);
		check(rd, 32'h0);
		check(32'({oe_n, chan_sel}), 32'({1'b1, CHAN_RST}));
		apb(1'b0, 8'h0c, 32'h0);
		check(32'(err), 32'h1);
		check(rd, 32'h0);
		chan = CHAN_RST;
		for (int i = 0; i < 6; i++)
			convert(i);
		print_verdict;
	end
	// Six conversions need about 19k cycles; this allows about five times that
	initial
	begin
		#800000;
		bad_count++;
		print_verdict;
	end
endmodule
